// file: rtl/dca_pkg.sv
// Purpose: constants for the average current and autozero message block
// Assumes: 32-bit message frames, 8 channels
// Notes: field positions follow the response layouts
package dca_pkg;
   localparam int FRAME_W = 32;
   localparam int CHANNEL_SELECT_W = 3;
   localparam int NUM_CHANNEL_SELECT = 8;
   localparam int SUM_W = 20;
   localparam int AZ_W = 8;
   localparam int RW_BIT = 31;
   localparam int ID_HI = 30;
   localparam int ID_LO = 27;
   localparam int CH_HI = 26;
   localparam int CH_LO = 24;
   localparam int AVG_VALID_BIT = 20;
   localparam int AZ_ON_DONE_BIT = 17;
   localparam int AZ_OFF_DONE_BIT = 16;
   localparam int AZ_ON_HI = 15;
   localparam int AZ_ON_LO = 8;
   localparam logic [3:0] ID_AVG_READ = 4'h6;
   localparam logic [3:0] ID_AZ = 4'h7;
   localparam logic [SUM_W-1:0] SUM_RESET = 20'h0_0000;
   localparam logic [AZ_W-1:0] AZ_RESET = 8'h00;
   localparam logic [CHANNEL_SELECT_W-1:0] CHANNEL_SELECT_RESET = 3'h0;
endpackage

// file: rtl/dca_sum_latch.sv
// Purpose: per-channel latch of one dither period current summation
// Assumes: sum and period end come from the current sense logic
// Notes: valid cleared on read or channel change, set wins over a read clear
`timescale 1ns/1ps
module dca_sum_latch
   import dca_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [CHANNEL_SELECT_W-1:0] chanSel,
   input wire logic chanChange,
   input wire logic readPulse,
   input wire logic [NUM_CHANNEL_SELECT-1:0] periodEnd,
   input wire logic [NUM_CHANNEL_SELECT*SUM_W-1:0] periodSum,
   output logic [SUM_W-1:0] avgSum,
   output logic avgValid
);
   logic [SUM_W-1:0] sumQ [NUM_CHANNEL_SELECT];
   logic [NUM_CHANNEL_SELECT-1:0] freshQ;
   logic validQ;
   // fresh marks a period that started after the last selection
   wire selEnd = periodEnd[chanSel] & freshQ[chanSel] & ~chanChange;

   genvar g;
   generate
      for (g = 0; g < NUM_CHANNEL_SELECT; g++) begin : gCh
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               sumQ[g] <= SUM_RESET;
               freshQ[g] <= 1'b0;
            end else begin
               if (periodEnd[g]) begin
                  sumQ[g] <= periodSum[g*SUM_W +: SUM_W];
               end
               // partial period after a switch is discarded
               if (chanChange && chanSel == CHANNEL_SELECT_W'(g)) begin
                  freshQ[g] <= 1'b0;
               end else if (periodEnd[g]) begin
                  freshQ[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         validQ <= 1'b0;
      end else if (selEnd) begin
         validQ <= 1'b1;
      end else if (readPulse || chanChange) begin
         validQ <= 1'b0;
      end
   end
   assign avgSum = sumQ[chanSel];
   assign avgValid = validQ;

   property p_valid_set;
      @(posedge core_clk) disable iff (!rst_n) selEnd |=> avgValid;
   endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid not set");
   property p_valid_clr;
      @(posedge core_clk) disable iff (!rst_n)
         (chanChange && !selEnd) |=> !avgValid;
   endproperty
   a_valid_clr: assert property (p_valid_clr) else $error("valid kept");
endmodule

// file: rtl/dca_msg_core.sv
// Purpose: average dither current read and autozero trigger/read messages
// Assumes: frame framing done outside; reqStrobe marks a whole request
// Notes: response word is registered one cycle after the request
`timescale 1ns/1ps
module dca_msg_core
   import dca_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reqStrobe,
   input wire logic [FRAME_W-1:0] reqWord,
   output logic [FRAME_W-1:0] respWord,
   output logic respStrobe,
   output logic [CHANNEL_SELECT_W-1:0] sharedChan,
   input wire logic [NUM_CHANNEL_SELECT-1:0] periodEnd,
   input wire logic [NUM_CHANNEL_SELECT*SUM_W-1:0] periodSum,
   output logic azStart,
   output logic [CHANNEL_SELECT_W-1:0] azChan,
   input wire logic azOnDone,
   input wire logic azOffDone,
   input wire logic [AZ_W-1:0] azOnValue,
   input wire logic [AZ_W-1:0] azOffValue
);
   // bits 23:0 of a request are never looked at
   wire [3:0] reqId = reqWord[ID_HI:ID_LO];
   wire [CHANNEL_SELECT_W-1:0] reqChan = reqWord[CH_HI:CH_LO];
   wire reqWrite = reqWord[RW_BIT];
   wire isAvg = reqStrobe && reqId == ID_AVG_READ;
   wire isAz = reqStrobe && reqId == ID_AZ;
   // average write behaves exactly like a read
   wire avgRead = isAvg;
   wire azWrite = isAz && reqWrite;
   wire azRead = isAz && !reqWrite;

   logic [CHANNEL_SELECT_W-1:0] chanQ, chanD;
   logic [AZ_W-1:0] onValQ, offValQ;
   logic onDoneQ, offDoneQ;
   logic [FRAME_W-1:0] respQ, respD;
   logic respStbQ;
   logic [SUM_W-1:0] avgSum;
   logic avgValid;

   wire chanChange = avgRead && reqChan != chanQ;
   assign chanD = avgRead ? reqChan : chanQ;

   // chanChange drops valid; a result waits one full fresh period
   dca_sum_latch uLatch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .chanSel(chanD),
      .chanChange(chanChange),
      .readPulse(avgRead),
      .periodEnd(periodEnd),
      .periodSum(periodSum),
      .avgSum(avgSum),
      .avgValid(avgValid)
   );

   // response packs the state seen at the request, before any clear except a channel switch
   always_comb begin
      respD = '0;
      respD[ID_HI:ID_LO] = reqId;
      respD[CH_HI:CH_LO] = reqChan;
      if (reqId == ID_AVG_READ) begin
         respD[AVG_VALID_BIT] = avgValid && !chanChange;
         // stale sum of new channel is not returned after a switch
         respD[SUM_W-1:0] = chanChange ? SUM_RESET : avgSum;
      end else if (reqId == ID_AZ) begin
         respD[AZ_ON_DONE_BIT] = onDoneQ;
         respD[AZ_OFF_DONE_BIT] = offDoneQ;
         respD[AZ_ON_HI:AZ_ON_LO] = onValQ;
         respD[AZ_W-1:0] = offValQ;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chanQ <= CHANNEL_SELECT_RESET;
         respQ <= '0;
         respStbQ <= 1'b0;
      end else begin
         chanQ <= chanD;
         respStbQ <= reqStrobe;
         if (reqStrobe) begin
            respQ <= respD;
         end
      end
   end

   // done sets win over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         onDoneQ <= 1'b0;
         offDoneQ <= 1'b0;
         onValQ <= AZ_RESET;
         offValQ <= AZ_RESET;
      end else begin
         if (azOnDone) begin
            onDoneQ <= 1'b1;
            onValQ <= azOnValue;
         end else if (isAz) begin
            onDoneQ <= 1'b0;
         end
         if (azOffDone) begin
            offDoneQ <= 1'b1;
            offValQ <= azOffValue;
         end else if (isAz) begin
            offDoneQ <= 1'b0;
         end
      end
   end

   assign respWord = respQ;
   assign respStrobe = respStbQ;
   assign sharedChan = chanQ;
   assign azStart = azWrite;
   // is the host's duty; no decay check here
   assign azChan = reqChan;

   property p_resp_hdr;
      @(posedge core_clk) disable iff (!rst_n)
         reqStrobe |=> respStrobe && !respWord[RW_BIT]
            && respWord[ID_HI:ID_LO] == $past(reqWord[ID_HI:ID_LO]);
   endproperty
   a_resp_hdr: assert property (p_resp_hdr) else $error("bad header");
   property p_channel_select_share;
      @(posedge core_clk) disable iff (!rst_n)
         avgRead |=> sharedChan == $past(reqChan);
   endproperty
   a_channel_select_share: assert property (p_channel_select_share) else $error("channel_select lost");
   property p_az_start;
      @(posedge core_clk) disable iff (!rst_n)
         azStart |-> reqStrobe && reqWord[RW_BIT]
            && reqWord[ID_HI:ID_LO] == ID_AZ
            && azChan == reqWord[CH_HI:CH_LO];
   endproperty
   a_az_start: assert property (p_az_start) else $error("bad start");
   property p_az_read;
      @(posedge core_clk) disable iff (!rst_n)
         (reqStrobe && reqWord[ID_HI:ID_LO] == ID_AZ && !reqWord[RW_BIT])
            |-> !azStart;
   endproperty
   a_az_read: assert property (p_az_read) else $error("read started");
   property p_az_clr;
      @(posedge core_clk) disable iff (!rst_n)
         (isAz && !azOnDone) |=> !onDoneQ;
   endproperty
   a_az_clr: assert property (p_az_clr) else $error("flag kept");
   property p_az_set;
      @(posedge core_clk) disable iff (!rst_n)
         azOffDone |=> offDoneQ && offValQ == $past(azOffValue);
   endproperty
   a_az_set: assert property (p_az_set) else $error("flag unset");
   property p_avg_data;
      @(posedge core_clk) disable iff (!rst_n)
         (avgRead && !chanChange) |=> respWord[SUM_W-1:0] == $past(avgSum);
   endproperty
   a_avg_data: assert property (p_avg_data) else $error("bad sum");
   property p_az_data;
      @(posedge core_clk) disable iff (!rst_n)
         isAz |=> respWord[AZ_ON_HI:AZ_ON_LO] == $past(onValQ);
   endproperty
   a_az_data: assert property (p_az_data) else $error("bad offset");
endmodule

// file: bench/dca_host_model.sv
// Purpose: host side that issues request frames to the message core
// Assumes: one request at a time, answer one cycle later
// Notes: request bus shows the inverse word once released
`timescale 1ns/1ps
module dca_host_model
   import dca_pkg::*;
(
   input wire logic core_clk,
   input wire logic respStrobe,
   output logic reqStrobe,
   output logic [FRAME_W-1:0] reqWord,
   output logic timedOut
);
   initial begin
      reqStrobe = 1'b0;
      reqWord = 32'h0000_0000;
      timedOut = 1'b0;
   end
   // no output stage here, so a trigger never meets a decaying current
   task automatic send(input logic wr, input logic [3:0] id,
         input logic [2:0] ch);
      int n;
      @(posedge core_clk);
      reqStrobe <= 1'b1;
      reqWord <= {wr, id, ch, 24'($urandom)};
      @(posedge core_clk);
      reqStrobe <= 1'b0;
      reqWord <= ~reqWord;
      #1;
      n = 0;
      while (respStrobe !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 4) timedOut = 1'b1;
   endtask
endmodule

// file: bench/testbench.sv
// Purpose: self-checking bench for the message core
// Assumes: host model drives requests; bench drives sense side
// Notes: reference state kept in plain variables, checked per reply
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin badCount++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench
   import dca_pkg::*;
;
   logic core_clk, rst_n, reqStrobe, respStrobe, azStart, timedOut;
   logic azOnDone, azOffDone, expStart;
   logic [FRAME_W-1:0] reqWord, respWord, expWord;
   logic [CHANNEL_SELECT_W-1:0] sharedChan, azChan, mChan, ch;
   logic [NUM_CHANNEL_SELECT-1:0] periodEnd;
   logic [NUM_CHANNEL_SELECT*SUM_W-1:0] periodSum;
   logic [AZ_W-1:0] azOnValue, azOffValue, mOnV, mOffV;
   logic [SUM_W-1:0] mSum;
   logic [SUM_W-1:0] mSums [NUM_CHANNEL_SELECT];
   logic mValid, mSkip, mOn, mOff;
   int badCount = 0;
   int compares = 0;
   dca_msg_core uut (.core_clk(core_clk), .rst_n(rst_n),
      .reqStrobe(reqStrobe), .reqWord(reqWord), .respWord(respWord),
      .respStrobe(respStrobe), .sharedChan(sharedChan),
      .periodEnd(periodEnd), .periodSum(periodSum), .azStart(azStart),
      .azChan(azChan), .azOnDone(azOnDone), .azOffDone(azOffDone),
      .azOnValue(azOnValue), .azOffValue(azOffValue));
   dca_host_model host (.core_clk(core_clk), .respStrobe(respStrobe),
      .reqStrobe(reqStrobe), .reqWord(reqWord), .timedOut(timedOut));
   always #25 core_clk = ~core_clk;
   assign expStart = reqStrobe & reqWord[RW_BIT] &
      (reqWord[ID_HI:ID_LO] == ID_AZ);
   always @(negedge core_clk) begin
      if (rst_n) begin
         `CHK(azStart, expStart)
         if (expStart) `CHK(azChan, reqWord[CH_HI:CH_LO])
      end
   end
   task automatic printVerdict();
      if (badCount == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic req(input logic wr, input logic [3:0] id,
         input logic [2:0] c);
      expWord = {1'b0, id, c, 24'h00_0000};
      if (id == ID_AVG_READ) begin
         if (c != mChan) begin
            {mValid, mSum, mSkip} = {1'b0, SUM_RESET, 1'b1};
         end else begin
            mSum = mSums[c];
         end
         mChan = c;
         expWord[20:0] = {mValid, mSum};
         mValid = 1'b0;
      end else if (id == ID_AZ) begin
         expWord[17:0] = {mOn, mOff, mOnV, mOffV};
         {mOn, mOff} = 2'b00;
      end
      host.send(wr, id, c);
      if (timedOut) begin
         badCount++;
         printVerdict();
      end
      `CHK(respWord, expWord)
      `CHK(sharedChan, mChan)
   endtask
   task automatic pend(input logic [2:0] g);
      logic [SUM_W-1:0] s;
      s = SUM_W'($urandom);
      @(posedge core_clk);
      periodEnd <= 8'h01 << g;
      periodSum[g*SUM_W+:SUM_W] <= s;
      @(posedge core_clk);
      periodEnd <= 8'h00;
      mSums[g] = s;
      if (g == mChan && mSkip) mSkip = 1'b0;
      else if (g == mChan) mValid = 1'b1;
   endtask
   task automatic azd(input logic on, input logic off);
      logic [AZ_W-1:0] a, b;
      a = AZ_W'($urandom);
      b = AZ_W'($urandom);
      @(posedge core_clk);
      {azOnDone, azOffDone, azOnValue, azOffValue} <= {on, off, a, b};
      @(posedge core_clk);
      {azOnDone, azOffDone} <= 2'b00;
      if (on) {mOn, mOnV} = {1'b1, a};
      if (off) {mOff, mOffV} = {1'b1, b};
   endtask
   // first period after reset or a switch never counts
   task automatic modelReset();
      {mChan, mValid, mSum, mSkip} = {CHANNEL_SELECT_RESET, 1'b0, SUM_RESET, 1'b1};
      {mOn, mOff, mOnV, mOffV} = '0;
      foreach (mSums[i]) mSums[i] = SUM_RESET;
   endtask
   initial begin
      {core_clk, rst_n, azOnDone, azOffDone} = 4'h0;
      {periodEnd, periodSum, azOnValue, azOffValue} = '0;
      modelReset();
      void'($urandom(98));
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      req(1'b0, ID_AZ, 3'h0);
      req(1'b0, ID_AVG_READ, 3'h0);
      ch = 3'($urandom_range(7, 1));
      req(1'b1, ID_AVG_READ, ch);
      pend(ch);
      pend(ch ^ 3'h1);
      req(1'b0, ID_AVG_READ, ch);
      pend(ch);
      req(1'b0, ID_AVG_READ, ch);
      req(1'b0, ID_AVG_READ, ch);
      req(1'b0, ID_AVG_READ, ch ^ 3'h1);
      pend(ch ^ 3'h1);
      req(1'b0, ID_AVG_READ, ch ^ 3'h1);
      req(1'b0, ID_AVG_READ, ch);
      pend(ch);
      req(1'b0, 4'h5, ch ^ 3'h2);
      req(1'b1, ID_AZ, ch ^ 3'h3);
      azd(1'b1, 1'b0);
      azd(1'b0, 1'b1);
      req(1'b0, ID_AZ, ch);
      req(1'b0, ID_AZ, ch);
      azd(1'b1, 1'b1);
      req(1'b1, ID_AZ, ch);
      for (int i = 0; i < 16; i++) req(1'b0, 4'(i), ch);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      modelReset();
      `CHK(respWord, 32'h0000_0000)
      `CHK(sharedChan, CHANNEL_SELECT_RESET)
      rst_n <= 1'b1;
      req(1'b0, ID_AZ, ch);
      req(1'b0, ID_AVG_READ, 3'h0);
      printVerdict();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      badCount++;
      printVerdict();
   end
endmodule
